// File: i2cdc_pkg.sv
// shared constants and types for the i2c dma and control block
package i2cdc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_ISR  = 8'hD0;
  localparam logic [7:0] OFF_IMR  = 8'hD4;
  localparam logic [7:0] OFF_RDAP = 8'hD8;
  localparam logic [7:0] OFF_RDC  = 8'hDC;
  localparam logic [7:0] OFF_TDAP = 8'hE0;
  localparam logic [7:0] OFF_TDC  = 8'hE4;
  localparam logic [7:0] OFF_OAR2 = 8'hE8;
  localparam logic [7:0] OFF_GCA  = 8'hEC;
  localparam logic [7:0] OFF_CTRL = 8'hF0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;

  // control register fields
  localparam int         CTRL_PE    = 5;
  localparam int         CTRL_GC    = 4;
  localparam int         CTRL_START = 3;
  localparam int         CTRL_ACK   = 2;
  localparam int         CTRL_STOP  = 1;
  localparam int         CTRL_ITE   = 0;
  localparam logic [7:0] CTRL_WR_MASK   = 8'h3F;
  localparam logic [7:0] CTRL_PE_MASK   = 8'h20;
  localparam logic [7:0] CTRL_STOP_MASK = 8'h02;

  // priority/pending register fields: pending err, rx, tx in [2:0], level in [6:4]
  localparam int ISR_PRL_LSB = 4;
  // mask register fields
  localparam int IMR_RECEIVE_DMA_ON  = 3;
  localparam int IMR_TRANSMIT_DMA_ON  = 4;
  localparam int IMR_RECEIVE_BLOCK_DONE_PENDING = 5;
  localparam int IMR_TRANSMIT_BLOCK_DONE_PENDING = 6;
  // target select in both counter pointer registers
  localparam int PTR_SEL = 0;
  // clock range field and ten-bit flag, locked while enabled
  localparam logic [7:0] OAR2_LOCK_MASK = 8'hE1;

  // transfer limits and interrupt vector low bits
  localparam logic [7:0] RF_MAX_TRANS = 8'hDE;
  localparam logic [2:0] VEC_ERR = 3'h2;
  localparam logic [2:0] VEC_RX  = 3'h4;
  localparam logic [2:0] VEC_TX  = 3'h6;

  // control bits handed to the byte-level protocol engine
  typedef struct packed {
    logic pe;
    logic gc;
    logic start;
    logic ack;
    logic stop;
    logic global_irq_allow;
  } i2cdc_ctl_t;

  // register file access, asynchronous read, write at the clock edge
  typedef struct packed {
    logic [7:0] addr;
    logic       we;
    logic [7:0] wdata;
  } i2cdc_rf_req_t;

  // memory access, req held until ack
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } i2cdc_mem_req_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_FETCH = 5'b00010,
    S_XFER  = 5'b00100,
    S_STORE = 5'b01000,
    S_END   = 5'b10000
  } i2cdc_st_t;

endpackage

// File: i2cdc_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module i2cdc_sync
  import i2cdc_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // capture chain
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept only a settled level
  always_ff @(posedge clk)
  begin
    if (srst)
      dout <= RST_VAL;
    else if (s2_r == s3_r)
      dout <= s3_r;
  end

endmodule

// File: i2cdc_chan.sv
// per-direction dma enable and end-of-block pending flag
`timescale 1ns/1ps
module i2cdc_chan
  import i2cdc_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic wr,
  input  wire logic wr_on,
  input  wire logic wr_done,
  input  wire logic eob,
  output logic      on_r,
  output logic      done_r
);

  // end of block drops the enable until software sets it again
  always_ff @(posedge clk)
  begin
    if (srst)
      on_r <= 1'b0;
    else if (eob)
      on_r <= 1'b0;
    else if (wr)
      on_r <= wr_on;
  end

  // pending flag: hardware set wins over a software clear
  always_ff @(posedge clk)
  begin
    if (srst)
      done_r <= 1'b0;
    else if (eob)
      done_r <= 1'b1;
    else if (wr)
      done_r <= done_r & wr_done;
  end

endmodule

// File: i2cdc_top.sv
// dma engine, control register and apb register file for the i2c interface
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module i2cdc_top
  import i2cdc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output i2cdc_ctl_t           ctl,
  output logic      [7:0]      own_high,
  output logic      [7:0]      gc_addr,
  input  wire logic            start_sent,
  input  wire logic            stop_sent,
  input  wire logic            err_event,
  input  wire logic            rx_event,
  input  wire logic            tx_event,
  input  wire logic            rx_byte_ready,
  input  wire logic [7:0]      rx_byte,
  input  wire logic            tx_byte_need,
  output logic      [7:0]      tx_byte,
  output logic                 dma_rx_done,
  output logic                 dma_tx_done,
  output logic                 dma_req,
  input  wire logic            dma_grant,
  output i2cdc_rf_req_t        rf_req,
  input  wire logic [7:0]      rf_rdata,
  output i2cdc_mem_req_t       mem_req,
  input  wire logic            mem_ack,
  input  wire logic [7:0]      mem_rdata,
  output logic                 irq_req,
  output logic      [2:0]      irq_vec,
  output logic      [2:0]      irq_prl,
  input  wire logic            scl_in,
  output logic                 scl_out,
  output logic                 scl_oe,
  output logic                 pin_alt_sel
);

  logic [7:0]     ctrl_r;
  logic [7:0]     oar2_r;
  logic [7:0]     gca_r;
  logic [7:0]     rdap_r;
  logic [7:0]     rdc_r;
  logic [7:0]     tdap_r;
  logic [7:0]     tdc_r;
  logic [2:0]     prl_r;
  logic [2:0]     pend_r;
  logic [2:0]     mask_r;
  logic [31:0]    prdata_r;
  i2cdc_st_t      state_r;
  logic [1:0]     step_r;
  logic           ph_r;
  logic           dir_r;
  logic           rfm_r;
  logic [15:0]    addr_r;
  logic [15:0]    cnt_r;
  i2cdc_rf_req_t  rf_req_r;
  i2cdc_mem_req_t mem_req_r;
  logic [7:0]     tx_byte_r;
  logic           done_rx_r;
  logic           done_tx_r;
  logic           hold_r;
  logic           scl_s;
  logic           rx_on;
  logic           tx_on;
  logic           reob;
  logic           teob;
  logic           pe;
  logic           wr_en;
  logic           rd_setup;
  logic           imr_wr;
  logic           mapped;
  logic [7:0]     rd_mux;
  logic           want_rx;
  logic           want_tx;
  logic           err_req;
  logic           rx_req;
  logic           tx_req;
  logic           last_step;
  logic           cnt_zero;
  logic           eob_rx;
  logic           eob_tx;
  logic           dma_pend;
  logic [7:0]     aptr_cur;
  logic [7:0]     cptr_cur;
  logic [7:0]     rf_cnt_ld;
  logic [2:0]     pend_set;

  // register-file location of one table byte
  function automatic logic [7:0] tbl_loc(input logic [1:0] step, input logic rfm,
                                         input logic [7:0] aptr, input logic [7:0] cptr);
    logic [7:0] base;
    base    = (rfm || step[1]) ? cptr : aptr;
    tbl_loc = {base[7:1], step[0]};
  endfunction

  // table byte written back at one step
  function automatic logic [7:0] tbl_byte(input logic [1:0] step, input logic rfm,
                                          input logic [15:0] a, input logic [15:0] c);
    logic [15:0] w;
    w = (rfm ? step[0] : step[1]) ? c : a;
    if (rfm || step[0])
      tbl_byte = w[7:0];
    else
      tbl_byte = w[15:8];
  endfunction

  // apb decode and handshake, no wait states
  assign pe       = ctrl_r[CTRL_PE];
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign imr_wr   = wr_en && (paddr == OFF_IMR);
  assign pready   = penable;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_r;

  // read multiplexer
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = REG_RST;
    unique case (paddr)
      OFF_CTRL: rd_mux = ctrl_r;
      OFF_ISR:  rd_mux = {1'b0, prl_r, 1'b0, pend_r};
      OFF_IMR:  rd_mux = {1'b0, teob, reob, tx_on, rx_on, mask_r};
      OFF_RDAP: rd_mux = rdap_r;
      OFF_RDC:  rd_mux = rdc_r;
      OFF_TDAP: rd_mux = tdap_r;
      OFF_TDC:  rd_mux = tdc_r;
      OFF_OAR2: rd_mux = oar2_r;
      OFF_GCA:  rd_mux = gca_r;
      default:  mapped = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      prdata_r <= 32'h00000000;
    else if (rd_setup)
      prdata_r <= {24'h000000, rd_mux};
  end

  // control register: two-step enable, disable clears all but stop
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl_r <= CTRL_RST;
    else if (wr_en && (paddr == OFF_CTRL))
    begin
      if (!pe || !pwdata[CTRL_PE])
        ctrl_r <= (pwdata[7:0] & CTRL_PE_MASK)
                | (pwdata[CTRL_PE] ? (ctrl_r & CTRL_STOP_MASK) : (pwdata[7:0] & CTRL_STOP_MASK));
      else
        ctrl_r <= pwdata[7:0] & CTRL_WR_MASK;
    end
    else
    begin
      if (start_sent)
        ctrl_r[CTRL_START] <= 1'b0;
      if (stop_sent)
        ctrl_r[CTRL_STOP] <= 1'b0;
    end
  end

  // own-address high and general call registers, locked bits while enabled
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      oar2_r <= REG_RST;
      gca_r  <= REG_RST;
    end
    else if (wr_en)
    begin
      if (paddr == OFF_OAR2)
        oar2_r <= pe ? ((oar2_r & OAR2_LOCK_MASK) | (pwdata[7:0] & ~OAR2_LOCK_MASK))
                     : pwdata[7:0];
      if ((paddr == OFF_GCA) && !pe)
        gca_r <= pwdata[7:0];
    end
  end

  // dma pointer registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdap_r <= REG_RST;
      rdc_r  <= REG_RST;
      tdap_r <= REG_RST;
      tdc_r  <= REG_RST;
    end
    else if (wr_en)
    begin
      if (paddr == OFF_RDAP)
        rdap_r <= pwdata[7:0];
      if (paddr == OFF_RDC)
        rdc_r <= pwdata[7:0];
      if (paddr == OFF_TDAP)
        tdap_r <= pwdata[7:0];
      if (paddr == OFF_TDC)
        tdc_r <= pwdata[7:0];
    end
  end

  // data interrupts need global enable and are replaced by dma when on
  assign pend_set = {tx_event && ctrl_r[CTRL_ITE] && !tx_on,
                     rx_event && ctrl_r[CTRL_ITE] && !rx_on,
                     err_event && ctrl_r[CTRL_ITE]};

  // priority level and pending bits, set wins over clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prl_r  <= 3'h0;
      pend_r <= 3'h0;
    end
    else
    begin
      if (wr_en && (paddr == OFF_ISR))
        prl_r <= pwdata[ISR_PRL_LSB +: 3];
      pend_r <= ((wr_en && (paddr == OFF_ISR)) ? (pend_r & pwdata[2:0]) : pend_r) | pend_set;
    end
  end

  // interrupt masks
  always_ff @(posedge clk)
  begin
    if (srst)
      mask_r <= 3'h0;
    else if (imr_wr)
      mask_r <= pwdata[2:0];
  end

  // per-direction dma enable and end-of-block state
  i2cdc_chan u_rx_chan (
    .clk     (clk),
    .srst    (srst),
    .wr      (imr_wr),
    .wr_on   (pwdata[IMR_RECEIVE_DMA_ON]),
    .wr_done (pwdata[IMR_RECEIVE_BLOCK_DONE_PENDING]),
    .eob     (eob_rx),
    .on_r    (rx_on),
    .done_r  (reob)
  );

  i2cdc_chan u_tx_chan (
    .clk     (clk),
    .srst    (srst),
    .wr      (imr_wr),
    .wr_on   (pwdata[IMR_TRANSMIT_DMA_ON]),
    .wr_done (pwdata[IMR_TRANSMIT_BLOCK_DONE_PENDING]),
    .eob     (eob_tx),
    .on_r    (tx_on),
    .done_r  (teob)
  );

  // request ranking: error, dma, receive, transmit
  assign err_req = pend_r[0] && mask_r[0];
  assign rx_req  = (pend_r[1] || reob) && mask_r[1];
  assign tx_req  = (pend_r[2] || teob) && mask_r[2];
  assign want_rx = pe && rx_on && rx_byte_ready;
  assign want_tx = pe && tx_on && tx_byte_need;
  assign dma_req = (state_r == S_IDLE) && !done_rx_r && !done_tx_r
                 && (want_rx || want_tx) && !err_req;
  assign irq_req = err_req || (!dma_req && (rx_req || tx_req));
  assign irq_vec = err_req ? VEC_ERR : (rx_req ? VEC_RX : VEC_TX);
  assign irq_prl = prl_r;

  // engine helpers
  assign aptr_cur  = dir_r ? tdap_r : rdap_r;
  assign cptr_cur  = dir_r ? tdc_r : rdc_r;
  assign last_step = step_r == (rfm_r ? 2'h1 : 2'h3);
  assign cnt_zero  = rfm_r ? (cnt_r[7:0] == 8'h00) : (cnt_r == 16'h0000);
  assign eob_rx    = (state_r == S_END) && !dir_r && cnt_zero;
  assign eob_tx    = (state_r == S_END) && dir_r && cnt_zero;
  assign rf_cnt_ld = (rf_rdata > RF_MAX_TRANS) ? RF_MAX_TRANS : rf_rdata;

  // dma engine: fetch table, move byte, write table back
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r   <= S_IDLE;
      step_r    <= 2'h0;
      ph_r      <= 1'b0;
      dir_r     <= 1'b0;
      rfm_r     <= 1'b0;
      addr_r    <= 16'h0000;
      cnt_r     <= 16'h0000;
      rf_req_r  <= '0;
      mem_req_r <= '0;
      tx_byte_r <= 8'h00;
      done_rx_r <= 1'b0;
      done_tx_r <= 1'b0;
    end
    else
    begin
      done_rx_r <= 1'b0;
      done_tx_r <= 1'b0;
      unique case (state_r)
        S_IDLE:
          if (dma_req && dma_grant)
          begin
            dir_r   <= !want_rx;
            rfm_r   <= want_rx ? rdc_r[PTR_SEL] : tdc_r[PTR_SEL];
            step_r  <= 2'h0;
            ph_r    <= 1'b0;
            state_r <= S_FETCH;
          end
        S_FETCH:
          if (!ph_r)
          begin
            rf_req_r.addr <= tbl_loc(step_r, rfm_r, aptr_cur, cptr_cur);
            ph_r          <= 1'b1;
          end
          else
          begin
            if (rfm_r ? step_r[0] : step_r[1])
            begin
              if (rfm_r)
                cnt_r <= {8'h00, rf_cnt_ld};
              else if (step_r[0])
                cnt_r[7:0] <= rf_rdata;
              else
                cnt_r[15:8] <= rf_rdata;
            end
            else
            begin
              if (rfm_r)
                addr_r <= {8'h00, rf_rdata};
              else if (step_r[0])
                addr_r[7:0] <= rf_rdata;
              else
                addr_r[15:8] <= rf_rdata;
            end
            ph_r <= 1'b0;
            if (last_step)
            begin
              step_r  <= 2'h0;
              state_r <= S_XFER;
            end
            else
              step_r <= step_r + 2'h1;
          end
        S_XFER:
          if (rfm_r)
          begin
            if (!ph_r)
            begin
              rf_req_r.addr  <= addr_r[7:0];
              rf_req_r.we    <= !dir_r;
              rf_req_r.wdata <= rx_byte;
              ph_r           <= 1'b1;
            end
            else
            begin
              rf_req_r.we <= 1'b0;
              if (dir_r)
                tx_byte_r <= rf_rdata;
              addr_r  <= addr_r + 16'h0001;
              cnt_r   <= cnt_r - 16'h0001;
              ph_r    <= 1'b0;
              state_r <= S_STORE;
            end
          end
          else if (!mem_req_r.req)
          begin
            mem_req_r.req   <= 1'b1;
            mem_req_r.we    <= !dir_r;
            mem_req_r.addr  <= addr_r;
            mem_req_r.wdata <= rx_byte;
          end
          else if (mem_ack)
          begin
            mem_req_r.req <= 1'b0;
            mem_req_r.we  <= 1'b0;
            if (dir_r)
              tx_byte_r <= mem_rdata;
            addr_r  <= addr_r + 16'h0001;
            cnt_r   <= cnt_r - 16'h0001;
            state_r <= S_STORE;
          end
        S_STORE:
          if (!ph_r)
          begin
            rf_req_r.addr  <= tbl_loc(step_r, rfm_r, aptr_cur, cptr_cur);
            rf_req_r.we    <= 1'b1;
            rf_req_r.wdata <= tbl_byte(step_r, rfm_r, addr_r, cnt_r);
            ph_r           <= 1'b1;
          end
          else
          begin
            rf_req_r.we <= 1'b0;
            ph_r        <= 1'b0;
            if (last_step)
              state_r <= S_END;
            else
              step_r <= step_r + 2'h1;
          end
        S_END:
        begin
          done_rx_r <= !dir_r;
          done_tx_r <= dir_r;
          state_r   <= S_IDLE;
        end
      endcase
    end
  end

  assign rf_req      = rf_req_r;
  assign mem_req     = mem_req_r;
  assign tx_byte     = tx_byte_r;
  assign dma_rx_done = done_rx_r;
  assign dma_tx_done = done_tx_r;

  // clock line sampled from the pin
  i2cdc_sync #(
    .RST_VAL (1'b1)
  ) u_scl_sync (
    .clk  (clk),
    .srst (srst),
    .din  (scl_in),
    .dout (scl_s)
  );

  // stretch the clock while a dma byte is outstanding
  assign dma_pend = want_rx || want_tx;
  always_ff @(posedge clk)
  begin
    if (srst || !pe)
      hold_r <= 1'b0;
    else if (!dma_pend)
      hold_r <= 1'b0;
    else if (!scl_s)
      hold_r <= 1'b1;
  end

  // pins and control outputs
  assign scl_out     = 1'b0;
  assign scl_oe      = hold_r && pe;
  assign pin_alt_sel = pe;
  assign own_high    = oar2_r;
  assign gc_addr     = gca_r;
  assign ctl.pe      = pe;
  assign ctl.gc      = ctrl_r[CTRL_GC];
  assign ctl.start   = ctrl_r[CTRL_START];
  assign ctl.ack     = ctrl_r[CTRL_ACK];
  assign ctl.stop    = ctrl_r[CTRL_STOP];
  assign ctl.global_irq_allow     = ctrl_r[CTRL_ITE];

endmodule

// File: i2cdc_props.sv
// assertion checker for the i2c dma and control block
`timescale 1ns/1ps
module i2cdc_props
  import i2cdc_pkg::*;
(
  input wire logic           clk,
  input wire logic           srst,
  input wire i2cdc_ctl_t     ctl,
  input wire logic [7:0]     own_high,
  input wire logic [7:0]     gc_addr,
  input wire logic           start_sent,
  input wire logic           rx_byte_ready,
  input wire logic           tx_byte_need,
  input wire logic           dma_rx_done,
  input wire logic           dma_tx_done,
  input wire logic           dma_req,
  input wire i2cdc_rf_req_t  rf_req,
  input wire i2cdc_mem_req_t mem_req,
  input wire logic           mem_ack,
  input wire logic           scl_oe,
  input wire logic           pin_alt_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // disabled: control cleared except stop, bus released
  property p_idle;
    !ctl.pe |-> !(ctl.gc | ctl.start | ctl.ack | ctl.global_irq_allow | scl_oe);
  endproperty
  a_idle: assert property (p_idle) else $error("control set while disabled");
  property p_alt;
    pin_alt_sel == ctl.pe;
  endproperty
  a_alt: assert property (p_alt) else $error("pin function not following enable");
  property p_first;
    $rose(ctl.pe) |-> !(ctl.gc | ctl.start | ctl.ack | ctl.global_irq_allow);
  endproperty
  a_first: assert property (p_first) else $error("enabling write set more than enable");
  property p_start;
    start_sent && ctl.start |=> !ctl.start;
  endproperty
  a_start: assert property (p_start) else $error("start not cleared when sent");
  property p_lock;
    ctl.pe && $past(ctl.pe) |-> $stable(gc_addr) && $stable(own_high & 8'hE1);
  endproperty
  a_lock: assert property (p_lock) else $error("locked field changed while enabled");
  property p_req;
    dma_req |-> ctl.pe && (rx_byte_ready || tx_byte_need);
  endproperty
  a_req: assert property (p_req) else $error("dma request without cause");
  property p_done;
    dma_rx_done || dma_tx_done |-> !dma_req ##1 !(dma_rx_done || dma_tx_done);
  endproperty
  a_done: assert property (p_done) else $error("done pulse too long or request beside it");
  property p_we;
    rf_req.we |=> !rf_req.we;
  endproperty
  a_we: assert property (p_we) else $error("register file write longer than a cycle");
  property p_mem;
    mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr);
  endproperty
  a_mem: assert property (p_mem) else $error("memory request dropped before ack");
endmodule

bind i2cdc_top i2cdc_props u_props (.*);

// File: i2cdc_far.sv
// register file and memory model on the dma side
`timescale 1ns/1ps
module i2cdc_far
  import i2cdc_pkg::*;
(
  input  wire logic           clk,
  input  wire i2cdc_rf_req_t  rf_req,
  output logic [7:0]          rf_rdata,
  input  wire i2cdc_mem_req_t mem_req,
  output logic                mem_ack,
  output logic [7:0]          mem_rdata
);
  logic [7:0] rf [256];
  logic [1:0] cnt_r;
  logic       slow_r = 1'b0;
  // register file: async read, write at the edge
  assign rf_rdata = rf[rf_req.addr];
  always @(posedge clk)
  begin
    if (rf_req.we)
      rf[rf_req.addr] <= rf_req.wdata;
  end
  // memory answers promptly and slowly in turn, data toggles when idle
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    cnt_r <= 2'h0;
    if (mem_req.req && !mem_ack)
    begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == {slow_r, slow_r})
      begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_req.addr[7:0] ^ 8'hA5;
        slow_r <= ~slow_r;
      end
    end
  end
endmodule

// File: i2c_dma_and_control_bench.sv
// self-checking bench for the i2c dma and control block
`timescale 1ns/1ps
module i2c_dma_and_control_bench
  import i2cdc_pkg::*;
;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, perr, start_sent, err_event;
  logic rx_byte_ready, tx_byte_need, dma_rx_done, dma_tx_done, dma_req, dma_grant;
  logic mem_ack, irq_req, scl_clk, scl_run, scl_in, scl_out, scl_oe, pin_alt_sel, saw_hold;
  logic [7:0]     paddr, own_high, gc_addr, rx_byte, tx_byte, rf_rdata, mem_rdata;
  logic [31:0]    pwdata, prdata, rdv;
  logic [2:0]     irq_vec, irq_prl;
  i2cdc_ctl_t     ctl;
  i2cdc_rf_req_t  rf_req;
  i2cdc_mem_req_t mem_req;
  int             err_count, comparisons, cyc;

  i2cdc_top dut (.rx_event(1'b0), .tx_event(1'b0), .stop_sent(1'b0), .*);
  i2cdc_far u_far (.*);

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // serial clock runs only during transfers; wired with our pull-down
  initial scl_clk = 1;
  always #32 scl_clk = scl_run ? ~scl_clk : 1'b1;
  assign scl_in = scl_clk & ~scl_oe;
  // protocol side: grant, level clear on done, hang limit
  always @(posedge clk)
  begin
    dma_grant <= dma_req;
    if (dma_rx_done) rx_byte_ready <= 0;
    if (dma_tx_done) tx_byte_need <= 0;
    if (scl_oe) saw_hold <= 1;
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(a, 0, 0);
    chk(rdv, {24'h0, e});
  endtask
  task automatic wait_done(input logic tx);
    do @(posedge clk); while ((tx ? dma_tx_done : dma_rx_done) !== 1'b1);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, start_sent, err_event, rx_byte_ready, tx_byte_need, dma_grant, scl_run, saw_hold} = 0;
    paddr = 0; pwdata = 0; rx_byte = 0; srst = 1; err_count = 0; comparisons = 0; cyc = 0;
    // tables inside the low register file window
    u_far.rf[8'h10] = 8'h20; u_far.rf[8'h11] = 8'h01;
    u_far.rf[8'h30] = 8'h12; u_far.rf[8'h31] = 8'h34;
    u_far.rf[8'h32] = 8'h00; u_far.rf[8'h33] = 8'h02;
    repeat (2) @(posedge clk);
    srst <= 0;
    rd(OFF_CTRL, CTRL_RST);
    apb(8'hFC, 0, 0);
    chk(perr, 1);
    wr(OFF_OAR2, 8'hE1);
    wr(OFF_CTRL, 8'h3D);
    rd(OFF_CTRL, 8'h20);
    wr(OFF_CTRL, 8'h3D);
    @(posedge clk);
    chk(ctl, 6'h3D);
    chk(pin_alt_sel, 1);
    start_sent <= 1;
    @(posedge clk);
    start_sent <= 0;
    rd(OFF_CTRL, 8'h35);
    wr(OFF_OAR2, 8'h00);
    wr(OFF_GCA, 8'h55);
    @(posedge clk);
    chk({own_high, gc_addr}, 16'hE100);
    // receive into the register file with interrupts globally off
    wr(OFF_CTRL, 8'h24);
    wr(OFF_RDC, 8'h11);
    wr(OFF_IMR, 8'h0A);
    scl_run <= 1; rx_byte <= 8'h5A; rx_byte_ready <= 1;
    wait_done(0);
    chk(u_far.rf[8'h20], 8'h5A);
    chk({u_far.rf[8'h10], u_far.rf[8'h11]}, 16'h2100);
    chk(saw_hold, 1);
    chk({irq_req, irq_vec}, {1'b1, VEC_RX});
    @(posedge clk);
    rx_byte_ready <= 1;
    repeat (20) @(posedge clk);
    chk(dma_req, 0);
    rd(OFF_IMR, 8'h22);
    rx_byte_ready <= 0; scl_run <= 0;
    // software answers receive block end with stop and no acknowledge
    wr(OFF_CTRL, 8'h22);
    rd(OFF_CTRL, 8'h22);
    // transmit from memory, two bytes
    wr(OFF_TDAP, 8'h30);
    wr(OFF_TDC, 8'h32);
    wr(OFF_IMR, 8'h10);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      tx_byte_need <= 1;
      wait_done(1);
      chk(tx_byte, 8'(8'h34 + i) ^ 8'hA5);
    end
    chk({u_far.rf[8'h31], u_far.rf[8'h33]}, 16'h3600);
    rd(OFF_IMR, 8'h40);
    // pending error holds off dma; oversized table count is limited
    u_far.rf[8'h11] = 8'hF0;
    wr(OFF_ISR, 8'h50);
    wr(OFF_CTRL, 8'h21);
    wr(OFF_IMR, 8'h09);
    err_event <= 1;
    rx_byte <= 8'hC3;
    @(posedge clk);
    err_event <= 0;
    rx_byte_ready <= 1;
    repeat (4) @(posedge clk);
    chk(dma_req, 0);
    chk({irq_req, irq_vec, irq_prl}, {1'b1, VEC_ERR, 3'h5});
    wr(OFF_ISR, 8'h50);
    wait_done(0);
    chk({u_far.rf[8'h21], u_far.rf[8'h11]}, 16'hC3DD);
    rd(OFF_ISR, 8'h50);
    wr(OFF_CTRL, 8'h02);
    rd(OFF_CTRL, 8'h02);
    chk({pin_alt_sel, scl_oe, scl_out}, 0);
    results();
  end
endmodule
